// ---- rtl/lsc_pkg.sv ----
package lsc_pkg;
  // ****************************************
  // Bus addressing
  // ****************************************
  localparam logic [6:0] LSC_DEV_ADDR = 7'h36;
  localparam logic [7:0] LSC_ADDR_FLAGS = 8'h03;
  localparam logic [7:0] LSC_ADDR_GATE = 8'h04;
  localparam logic [7:0] LSC_ADDR_THRESH = 8'h05;
  localparam logic [7:0] LSC_ADDR_PCUR = 8'h06;
  localparam logic [7:0] LSC_ADDR_PTIME = 8'h07;
  localparam logic [7:0] LSC_ADDR_VIN = 8'h08;
  localparam logic [7:0] LSC_ADDR_TAG = 8'h09;
  localparam logic [7:0] LSC_ADDR_XTRIP = 8'h0E;
  localparam logic [7:0] LSC_ADDR_RAMP = 8'h0F;
  // ****************************************
  // Reset values and field masks
  // ****************************************
  localparam logic [7:0] LSC_RST_GATE = 8'hF7;
  localparam logic [7:0] LSC_RST_THRESH = 8'h30;
  localparam logic [7:0] LSC_RST_RAMP = 8'h02;
  localparam logic [7:0] LSC_RST_ZERO = 8'h00;
  localparam logic [7:0] LSC_MASK_FLAGS = 8'h07;
  localparam logic [7:0] LSC_MASK_GATE = 8'hF7;
  localparam logic [7:0] LSC_MASK_THRESH = 8'h7B;
  localparam logic [7:0] LSC_MASK_PCUR = 8'h0F;
  localparam logic [7:0] LSC_MASK_XTRIP = 8'h03;
  localparam logic [7:0] LSC_MASK_RAMP = 8'h07;
  localparam int LSC_BIT_SURGE = 2;
  localparam int LSC_BIT_SHORT = 1;
  localparam int LSC_BIT_HEAT = 0;
  localparam int LSC_BIT_SRC_SEL = 3;
  localparam int LSC_GATE_STS_LSB = 4;
  // ****************************************
  // Serial engine states
  // ****************************************
  typedef enum logic [2:0] {
    LSC_IDLE, LSC_DEVADR, LSC_ACK_DEV, LSC_WR_BYTE, LSC_ACK_WR,
    LSC_RD_BYTE, LSC_ACK_RD
  } lsc_state_t;
endpackage

// ---- rtl/lsc_regs.sv ----
`timescale 1ns/1ps
// Contract
// - Alert low while any unmasked flag set
// - Overvoltage trip sets flag bit 2
// - Short-circuit trip sets flag bit 1
// - Over-temperature trip sets flag bit 0
// - Mask gates flag and status interrupts
// - Mask one passes; resets F7
// - Mask bits map status and flag sources
// - Source select: pin or register threshold
// - Fine trim bits 6:4, reset 3
// - Coarse threshold bits 1:0, reset 0
// - Probe current setting bits 3:0
// - Pulse width and duty, reset 0
// - Read-only input voltage code register
// - Extra trip level bits 1:0
// - Ramp rate trim bits 2:0, reset 2
// - Status bit rises raise interrupt
// - No general call, stretching, 10-bit
// - Answers at write 6C, read 6D
module lsc_regs import lsc_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic surge_trip,
  input wire logic short_trip,
  input wire logic heat_trip,
  input wire logic input_present_state,
  input wire logic below_tag_state,
  input wire logic detect_timer_expired_state,
  input wire logic switch_closed_state,
  input wire logic [7:0] input_voltage_code,
  output logic alert_n,
  output logic threshold_source_select,
  output logic [2:0] fine_trim,
  output logic [1:0] coarse_threshold,
  output logic [3:0] probe_current_setting,
  output logic [3:0] probe_pulse_width,
  output logic [3:0] probe_duty_setting,
  output logic [7:0] tag_voltage_code,
  output logic [1:0] extra_trip_setting,
  output logic [2:0] ramp_rate_setting
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [9:0] sync_a;
  logic [9:0] sync_b;
  logic scl_q;
  logic sda_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Idle levels: lines high, trips and status low.
      // Anything else would read as an edge just after reset.
      sync_a <= 10'h300;
      sync_b <= 10'h300;
    end else begin
      sync_a <= {scl_in, sda_in, surge_trip, short_trip, heat_trip,
                 input_present_state, below_tag_state,
                 detect_timer_expired_state, switch_closed_state, 1'b0};
      sync_b <= sync_a;
    end
  end
  logic scl_s, sda_s;
  logic [2:0] trip_s;
  logic [3:0] sts_s;
  assign scl_s = sync_b[9];
  assign sda_s = sync_b[8];
  assign trip_s = sync_b[7:5];
  assign sts_s = sync_b[4:1];
  // ADC code taken as levels; a code changing mid-sample may tear
  logic [7:0] vin_a;
  logic [7:0] vin_b;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vin_a <= LSC_RST_ZERO;
      vin_b <= LSC_RST_ZERO;
    end else begin
      vin_a <= input_voltage_code;
      vin_b <= vin_a;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c = scl_s & scl_q & ~sda_q & sda_s;
  // ****************************************
  // Serial engine
  // ****************************************
  lsc_state_t state;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic have_ptr;
  logic [7:0] ptr;
  logic [7:0] tx;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] rd_data;
  // Eighth bit seen; the SCL fall that follows START must not count
  logic byte_full;
  // Last acked byte was data, so the pointer moves on
  logic data_acked;
  function automatic logic [7:0] lsc_read(input logic [7:0] a,
                                          input logic [7:0] f,
                                          input logic [7:0] g,
                                          input logic [7:0] t,
                                          input logic [7:0] c,
                                          input logic [7:0] p,
                                          input logic [7:0] v,
                                          input logic [7:0] tg,
                                          input logic [7:0] x,
                                          input logic [7:0] r);
    unique case (a)
      LSC_ADDR_FLAGS: lsc_read = f;
      LSC_ADDR_GATE: lsc_read = g;
      LSC_ADDR_THRESH: lsc_read = t;
      LSC_ADDR_PCUR: lsc_read = c;
      LSC_ADDR_PTIME: lsc_read = p;
      LSC_ADDR_VIN: lsc_read = v;
      LSC_ADDR_TAG: lsc_read = tg;
      LSC_ADDR_XTRIP: lsc_read = x;
      LSC_ADDR_RAMP: lsc_read = r;
      default: lsc_read = LSC_RST_ZERO;
    endcase
  endfunction
  logic [7:0] flags, gate, thresh, pcur, ptime, tagv, xtrip, ramp;
  assign rd_data = lsc_read(ptr, flags, gate, thresh, pcur, ptime, vin_b,
                            tagv, xtrip, ramp);
  // Never holds SCL low: data changes only after a falling edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= LSC_IDLE;
      shift <= LSC_RST_ZERO;
      bit_cnt <= 3'h0;
      have_ptr <= 1'b0;
      ptr <= LSC_RST_ZERO;
      tx <= LSC_RST_ZERO;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      byte_full <= 1'b0;
      data_acked <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (start_c) begin
        state <= LSC_DEVADR;
        bit_cnt <= 3'h0;
        have_ptr <= 1'b0;
        sda_oe <= 1'b0;
        byte_full <= 1'b0;
        data_acked <= 1'b0;
      end else if (stop_c) begin
        state <= LSC_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          LSC_IDLE: sda_oe <= 1'b0;
          LSC_DEVADR, LSC_WR_BYTE: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 3'h1;
              byte_full <= (bit_cnt == 3'h7);
            end
            if (scl_fall && byte_full && state == LSC_DEVADR &&
                shift[7:1] != LSC_DEV_ADDR) begin
              // General call and foreign addresses go unanswered
              state <= LSC_IDLE;
            end else if (scl_fall && byte_full &&
                         state == LSC_DEVADR) begin
              state <= LSC_ACK_DEV;
              sda_oe <= 1'b1;
              byte_full <= 1'b0;
            end else if (scl_fall && byte_full) begin
              state <= LSC_ACK_WR;
              sda_oe <= 1'b1;
              byte_full <= 1'b0;
              if (have_ptr) begin
                wr_stb <= 1'b1;
                data_acked <= 1'b1;
              end else begin
                ptr <= shift;
                have_ptr <= 1'b1;
              end
            end
          end
          LSC_ACK_DEV: begin
            if (scl_fall && shift[0]) begin
              state <= LSC_RD_BYTE;
              tx <= rd_data;
              rd_stb <= 1'b1;
              sda_oe <= ~rd_data[7];
            end else if (scl_fall) begin
              state <= LSC_WR_BYTE;
              sda_oe <= 1'b0;
            end
          end
          LSC_ACK_WR: begin
            if (scl_fall) begin
              state <= LSC_WR_BYTE;
              sda_oe <= 1'b0;
              data_acked <= 1'b0;
              // Only a data byte advances the pointer
              if (data_acked) begin
                ptr <= ptr + 8'h01;
              end
            end
          end
          LSC_RD_BYTE: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7) begin
                state <= LSC_ACK_RD;
                sda_oe <= 1'b0;
                ptr <= ptr + 8'h01;
              end else begin
                tx <= {tx[6:0], 1'b0};
                sda_oe <= ~tx[6];
              end
            end
          end
          LSC_ACK_RD: begin
            // NACK ends the read; only START or STOP follows
            if (scl_rise && sda_s) begin
              state <= LSC_IDLE;
            end else if (scl_fall) begin
              state <= LSC_RD_BYTE;
              bit_cnt <= 3'h0;
              tx <= rd_data;
              rd_stb <= 1'b1;
              sda_oe <= ~rd_data[7];
            end
          end
          // Eighth encoding is unused
          default: state <= LSC_IDLE;
        endcase
      end
    end
  end
  // ****************************************
  // Writable registers
  // ****************************************
  logic [7:0] wr_addr;
  assign wr_addr = ptr;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gate <= LSC_RST_GATE;
      thresh <= LSC_RST_THRESH;
      pcur <= LSC_RST_ZERO;
      ptime <= LSC_RST_ZERO;
      tagv <= LSC_RST_ZERO;
      xtrip <= LSC_RST_ZERO;
      ramp <= LSC_RST_RAMP;
    end else if (wr_stb) begin
      unique case (wr_addr)
        LSC_ADDR_GATE: gate <= shift & LSC_MASK_GATE;
        LSC_ADDR_THRESH: thresh <= shift & LSC_MASK_THRESH;
        LSC_ADDR_PCUR: pcur <= shift & LSC_MASK_PCUR;
        LSC_ADDR_PTIME: ptime <= shift;
        LSC_ADDR_TAG: tagv <= shift;
        LSC_ADDR_XTRIP: xtrip <= shift & LSC_MASK_XTRIP;
        LSC_ADDR_RAMP: ramp <= shift & LSC_MASK_RAMP;
        default: ;
      endcase
    end
  end
  // ****************************************
  // Event flags and status edges
  // ****************************************
  logic [2:0] trip_q;
  logic [3:0] sts_q;
  logic [3:0] sts_evt;
  logic clr_flags;
  assign clr_flags = rd_stb && ptr == LSC_ADDR_FLAGS;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trip_q <= 3'h0;
      sts_q <= 4'h0;
      flags <= LSC_RST_ZERO;
      sts_evt <= 4'h0;
    end else begin
      trip_q <= trip_s;
      sts_q <= sts_s;
      // Set wins over read-clear so no trip is lost
      flags <= ((clr_flags ? LSC_RST_ZERO : flags) |
        {5'h00, trip_s & ~trip_q}) & LSC_MASK_FLAGS;
      // Status events stay pending until a flag read
      sts_evt <= (clr_flags ? 4'h0 : sts_evt) | (sts_s & ~sts_q);
    end
  end
  logic [7:0] pending;
  assign pending = {sts_evt, 1'b0, flags[2:0]};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= ~|(pending & gate);
    end
  end
  // ****************************************
  // Field outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      threshold_source_select <= 1'b0;
      fine_trim <= 3'h3;
      coarse_threshold <= 2'h0;
      probe_current_setting <= 4'h0;
      probe_pulse_width <= 4'h0;
      probe_duty_setting <= 4'h0;
      tag_voltage_code <= LSC_RST_ZERO;
      extra_trip_setting <= 2'h0;
      ramp_rate_setting <= 3'h2;
    end else begin
      threshold_source_select <= thresh[LSC_BIT_SRC_SEL];
      fine_trim <= thresh[6:4];
      coarse_threshold <= thresh[1:0];
      probe_current_setting <= pcur[3:0];
      probe_pulse_width <= ptime[7:4];
      probe_duty_setting <= ptime[3:0];
      tag_voltage_code <= tagv;
      extra_trip_setting <= xtrip[1:0];
      ramp_rate_setting <= ramp[2:0];
    end
  end
endmodule // lsc_regs

// ---- verification/lsc_regs_assertions.sv ----
`timescale 1ns/1ps
module lsc_regs_assertions import lsc_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic surge_trip,
  input wire logic short_trip,
  input wire logic heat_trip,
  input wire logic input_present_state,
  input wire logic below_tag_state,
  input wire logic detect_timer_expired_state,
  input wire logic switch_closed_state,
  input wire logic alert_n,
  input wire logic [2:0] fine_trim,
  input wire logic [1:0] coarse_threshold,
  input wire logic [2:0] ramp_rate_setting,
  input wire logic [7:0] tag_voltage_code
);
  logic [6:0] ev;
  logic [7:0] since_oe;
  logic [7:0] since_rise;
  logic untouched;
  assign ev = {surge_trip, short_trip, heat_trip, input_present_state,
    below_tag_state, detect_timer_expired_state, switch_closed_state};
  // Register updates and alert releases only follow bus traffic
  always_ff @(posedge clk) begin
    if (sys_rst || sda_oe)
      since_oe <= 8'h00;
    else if (since_oe != 8'hFF)
      since_oe <= since_oe + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (sys_rst || |(ev & ~$past(ev)))
      since_rise <= 8'h00;
    else if (since_rise != 8'hFF)
      since_rise <= since_rise + 8'h01;
  end
  // Mask still at its reset value until the first bus transfer
  always_ff @(posedge clk) begin
    if (sys_rst)
      untouched <= 1'b1;
    else if (sda_oe)
      untouched <= 1'b0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence heat_rise;
    $rose(heat_trip) && untouched;
  endsequence
  reset_vals_a: assert property ($fell(sys_rst) |->
    alert_n && !sda_oe && fine_trim == 3'h3 && coarse_threshold == 2'h0 &&
    ramp_rate_setting == 3'h2 && tag_voltage_code == 8'h00)
    else $error("bad values after reset");
  drain_only_a: assert property (!sda_out)
    else $error("data line driven high");
  ack_after_fall_a: assert property ($rose(sda_oe) |->
    !scl_in && !$past(scl_in, 2)) else $error("drive began with clock high");
  release_low_a: assert property ($fell(sda_oe) |->
    !scl_in && !$past(scl_in, 2)) else $error("release with clock high");
  fields_by_bus_a: assert property ($changed({fine_trim,
    coarse_threshold, ramp_rate_setting, tag_voltage_code}) |->
    since_oe < 8'h04) else $error("field changed without a write");
  trip_alert_a: assert property (heat_rise |-> ##[1:10] !alert_n)
    else $error("alert missing after trip");
  alert_cause_a: assert property ($fell(alert_n) |->
    since_rise < 8'h0C || since_oe < 8'h28) else $error("alert without cause");
  alert_release_a: assert property ($rose(alert_n) |->
    since_oe < 8'h28) else $error("alert released without a read");
endmodule // lsc_regs_assertions

// ---- verification/lsc_host.sv ----
`timescale 1ns/1ps
module lsc_host import lsc_pkg::*; (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  localparam int HALF = 10;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Data moves only while the clock is low, sampled at end of high
  task automatic xfer(input logic b, output logic r);
    tick(2);
    sda_low = ~b;
    tick(HALF - 2);
    scl = 1'b1;
    tick(HALF);
    r = sda;
    scl = 1'b0;
  endtask
  // s=1 start or repeated start, s=0 stop
  task automatic frame(input logic s);
    tick(2);
    sda_low = ~s;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = s;
    tick(HALF);
    scl = ~s;
  endtask
  task automatic put(input logic [7:0] b, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer(b[i], r);
    xfer(1'b1, r);
    ok = ok & ~r;
  endtask
  task automatic probe(input logic [7:0] b, output logic ok);
    ok = 1'b1;
    frame(1'b1);
    put(b, ok);
    frame(1'b0);
  endtask
  task automatic wr(input logic [7:0] a, v, output logic ok);
    ok = 1'b1;
    frame(1'b1);
    put({LSC_DEV_ADDR, 1'b0}, ok);
    put(a, ok);
    put(v, ok);
    frame(1'b0);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic ok);
    logic r;
    ok = 1'b1;
    frame(1'b1);
    put({LSC_DEV_ADDR, 1'b0}, ok);
    put(a, ok);
    frame(1'b1);
    put({LSC_DEV_ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--)
      xfer(1'b1, v[i]);
    xfer(1'b1, r);
    frame(1'b0);
  endtask
endmodule // lsc_host

// ---- verification/tb_lsc_regs.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: %h %h", $time, (g), (e)); end end
module tb_lsc_regs import lsc_pkg::*;;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] trip = 3'h0;
  logic [3:0] sts = 4'h0;
  logic [7:0] vin = 8'hA5;
  logic scl, sda_low, sda_oe, sda_out, alert_n, ok, threshold_source_select;
  logic [2:0] fine_trim, ramp_rate_setting;
  logic [1:0] coarse_threshold, extra_trip_setting;
  logic [3:0] probe_current_setting, probe_pulse_width, probe_duty_setting;
  logic [7:0] tag_voltage_code, d;
  wire sda;
  int errors = 0;
  int tests_run = 0;
  logic [7:0] ra [9] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0E,
    8'h0F, 8'h0A};
  logic [7:0] re [9] = '{8'hF7, 8'h30, 8'h00, 8'h00, 8'hA5, 8'h00, 8'h00,
    8'h02, 8'h00};
  logic [7:0] wa [8] = '{8'h05, 8'h06, 8'h07, 8'h09, 8'h0E, 8'h0F, 8'h08,
    8'h04};
  logic [7:0] wd [8] = '{8'hFF, 8'hFF, 8'h5A, 8'hC3, 8'hFF, 8'hFF, 8'h11,
    8'hF8};
  logic [7:0] we [8] = '{8'h7B, 8'h0F, 8'h5A, 8'hC3, 8'h03, 8'h07, 8'hA5,
    8'hF0};
  always #50 clk = ~clk;
  assign sda = ~(sda_oe | sda_low);
  lsc_host lsc_host_i (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  lsc_regs lsc_regs_i (.clk(clk), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .surge_trip(trip[2]),
    .short_trip(trip[1]), .heat_trip(trip[0]), .input_present_state(sts[3]),
    .below_tag_state(sts[2]), .detect_timer_expired_state(sts[1]),
    .switch_closed_state(sts[0]), .input_voltage_code(vin), .alert_n(alert_n),
    .threshold_source_select(threshold_source_select), .fine_trim(fine_trim),
    .coarse_threshold(coarse_threshold), .tag_voltage_code(tag_voltage_code),
    .probe_current_setting(probe_current_setting),
    .probe_pulse_width(probe_pulse_width), .ramp_rate_setting(ramp_rate_setting),
    .probe_duty_setting(probe_duty_setting),
    .extra_trip_setting(extra_trip_setting));
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    lsc_host_i.rd(a, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    finish_test();
  end
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    trip[0] = 1'b1;
    repeat (10) @(negedge clk);
    `CHK(alert_n, 1'b0)
    rd_chk(8'h03, 8'h01);
    `CHK(alert_n, 1'b1)
    trip = 3'h6;
    repeat (10) @(negedge clk);
    rd_chk(8'h03, 8'h06);
    rd_chk(8'h03, 8'h00);
    $display("flag test done");
    for (int i = 0; i < 9; i++)
      rd_chk(ra[i], re[i]);
    $display("reset value test done");
    for (int i = 0; i < 8; i++) begin
      lsc_host_i.wr(wa[i], wd[i], ok);
      `CHK(ok, 1'b1)
      rd_chk(wa[i], we[i]);
    end
    `CHK({threshold_source_select, fine_trim, coarse_threshold}, 6'h3F)
    `CHK({probe_current_setting, probe_pulse_width}, 8'hF5)
    `CHK({tag_voltage_code, extra_trip_setting}, 10'h30F)
    `CHK({probe_duty_setting, ramp_rate_setting}, 7'h57)
    $display("write test done");
    for (int i = 0; i < 4; i++) begin
      lsc_host_i.wr(8'h04, 8'h00, ok);
      sts[i] = 1'b1;
      repeat (10) @(negedge clk);
      `CHK(alert_n, 1'b1)
      lsc_host_i.wr(8'h04, 8'h10 << i, ok);
      `CHK(alert_n, 1'b0)
      rd_chk(8'h03, 8'h00);
      `CHK(alert_n, 1'b1)
      sts[i] = 1'b0;
    end
    $display("mask test done");
    lsc_host_i.probe(8'h00, ok);
    `CHK(ok, 1'b0)
    $display("general call test done");
    finish_test();
  end
endmodule // tb_lsc_regs
bind lsc_regs lsc_regs_assertions lsc_regs_assertions_i (.clk(clk),
  .sys_rst(sys_rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .surge_trip(surge_trip), .short_trip(short_trip), .heat_trip(heat_trip),
  .input_present_state(input_present_state), .alert_n(alert_n),
  .below_tag_state(below_tag_state), .switch_closed_state(switch_closed_state),
  .detect_timer_expired_state(detect_timer_expired_state),
  .fine_trim(fine_trim), .coarse_threshold(coarse_threshold),
  .ramp_rate_setting(ramp_rate_setting), .tag_voltage_code(tag_voltage_code));
